// ---- rtl/mcr_pkg.sv ----
// Constants for the miscellaneous control register block
package mcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [7:0] MISC_ONE_ADDR = 8'h20;
    localparam logic [7:0] MISC_TWO_ADDR = 8'h40;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h44;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h48;
    localparam logic [7:0] MISC_RESET = 8'h00;
    // Register one fields
    localparam int PB_SENSE_LSB = 6;
    localparam int CLKOUT_BIT = 5;
    localparam int PAF_SENSE_LSB = 3;
    localparam int SLOW_DIV_LSB = 1;
    localparam int SLOW_MODE_BIT = 0;
    // Register two fields
    localparam int PA_INV_BIT = 7;
    localparam int PB_INV_BIT = 6;
    localparam int TONE_LSB = 4;
    localparam int TOP_EDGE_BIT = 3;
    localparam int TOP_EN_BIT = 2;
    localparam int SS_SRC_BIT = 1;
    localparam int SS_LVL_BIT = 0;
    // Sensitivity codes
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    // Slow divider codes
    localparam logic [1:0] SLOW_DIV4 = 2'h0;
    localparam logic [1:0] SLOW_DIV8 = 2'h2;
    localparam logic [1:0] SLOW_DIV16 = 2'h1;
    localparam logic [1:0] SLOW_DIV32 = 2'h3;
    localparam logic [5:0] NORMAL_RATIO = 6'h02;
    localparam logic [5:0] RATIO_DIV4 = 6'h04;
    localparam logic [5:0] RATIO_DIV8 = 6'h08;
    localparam logic [5:0] RATIO_DIV16 = 6'h10;
    localparam logic [5:0] RATIO_DIV32 = 6'h20;
    // Tone codes and timing, as a ratio of the oscillator
    localparam logic [1:0] TONE_OFF = 2'h0;
    localparam logic [1:0] TONE_HIGH = 2'h1;
    localparam logic [1:0] TONE_MID = 2'h2;
    localparam logic [1:0] TONE_LOW = 2'h3;
    localparam int REF_OSC_HZ = 16_000_000;
    localparam int TONE_HIGH_HZ = 2_000;
    localparam int TONE_HALF_HIGH = REF_OSC_HZ / (2 * TONE_HIGH_HZ);
    // Interrupt status bit positions
    localparam int ST_PA = 0;
    localparam int ST_PF = 1;
    localparam int ST_PB_LOW = 2;
    localparam int ST_PB_HIGH = 3;
    localparam int ST_TOP = 4;
    localparam int IRQ_W = 5;
endpackage

// ---- rtl/mcr_sense.sv ----
// One external interrupt group: synchroniser and sensitivity decoder
`timescale 1ns/1ps
module mcr_sense
    import mcr_pkg::*;
#(
    parameter int W = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and settings
    input wire logic [W-1:0] pins,
    input wire logic [1:0] sense_sel,
    input wire logic invert,
    // Request
    output logic req
);
    logic [W-1:0] meta_q, sync_q, prev_q;
    logic [W-1:0] cur, old, hit;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end
        else
        begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Inversion turns falling into rising and low into high
    assign cur = invert ? ~sync_q : sync_q;
    assign old = invert ? ~prev_q : prev_q;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_pin
            always_comb
            begin
                case (sense_sel)
                    SENSE_FALL_LOW: hit[i] = ~cur[i];
                    SENSE_RISE: hit[i] = ~old[i] & cur[i];
                    SENSE_FALL: hit[i] = old[i] & ~cur[i];
                    SENSE_BOTH: hit[i] = old[i] ^ cur[i];
                    default: hit[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign req = |hit;
endmodule

// ---- rtl/mcr_top.sv ----
// Miscellaneous control registers with pin and clock functions
//
// Contract
// - Port B field selects four sensitivity codes
// - Port A/F field uses same coding
// - Sensitivity fields writable only at level three
// - Clock-out bit puts oscillator/2 on pin
// - Clock-out stops during active halt
// - Slow prescaler divides by 4,8,16,32
// - Normal mode divides oscillator by two
// - Port A polarity bit inverts sensitivity
// - Port B polarity bit inverts sensitivity; code inverts pins 3:0 only
// - Tone field selects off or three tones
// - Tone keeps running in active halt
// - Top edge bit changes only while disabled
// - Top enable turns pin detection on
// - Clearing top enable may cause spurious interrupt
// - Slave-select from pin or internal bit
// - Both control registers reset to zero
`timescale 1ns/1ps
module mcr_top
    import mcr_pkg::*;
#(
    parameter int TONE_HALF = TONE_HALF_HIGH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // CPU state
    input wire logic cpu_irq_level_high_bit,
    input wire logic cpu_irq_level_low_bit,
    input wire logic active_halt,
    // Interrupt pins
    input wire logic [3:0] porta_irq_pins,
    input wire logic [7:0] portb_irq_pins,
    input wire logic [2:0] portf_irq_pins,
    input wire logic top_irq_pin,
    // Group requests and summary interrupt
    output logic [3:0] ext_irq_req,
    output logic top_level_interrupt,
    output logic irq,
    // Clock functions
    output logic cpu_clk_en,
    output logic clock_out_pin,
    output logic clock_out_sel,
    output logic tone_pin,
    output logic tone_sel,
    // Slave select
    input wire logic slave_select_pin_n,
    output logic spi_ss_level_n,
    output logic slave_select_pin_free
);
    logic [7:0] misc_control_one_q, misc_control_two_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_events;
    logic [DATA_W-1:0] rdata_q;
    logic [3:0] ext_irq_req_q, grp_req;
    logic [5:0] div_cnt_q, div_ratio;
    logic [15:0] tone_cnt_q, tone_half;
    logic top_level_interrupt_q, irq_q, cpu_clk_en_q, tone_pin_q, tone_sel_q;
    logic clock_out_pin_q, clock_out_sel_q, spi_ss_level_n_q;
    logic top_meta_q, top_sync_q, top_prev_q, ss_meta_q, ss_sync_q;
    logic slave_select_pin_free_q, top_edge, level_three, wr_one, wr_two;

    // Field views
    logic [1:0] portb_irq_sense_sel, porta_portf_irq_sense_sel;
    logic [1:0] slow_clock_divider_sel, tone_select;
    logic clock_out_enable, slow_mode_select, top_irq_enable;
    logic porta_irq_polarity_invert, portb_irq_polarity_invert;
    logic top_irq_edge_select, slave_select_source;
    logic slave_select_internal_level;

    assign portb_irq_sense_sel = misc_control_one_q[PB_SENSE_LSB +: 2];
    assign porta_portf_irq_sense_sel = misc_control_one_q[PAF_SENSE_LSB +: 2];
    assign clock_out_enable = misc_control_one_q[CLKOUT_BIT];
    assign slow_clock_divider_sel = misc_control_one_q[SLOW_DIV_LSB +: 2];
    assign slow_mode_select = misc_control_one_q[SLOW_MODE_BIT];
    assign porta_irq_polarity_invert = misc_control_two_q[PA_INV_BIT];
    assign portb_irq_polarity_invert = misc_control_two_q[PB_INV_BIT];
    assign tone_select = misc_control_two_q[TONE_LSB +: 2];
    assign top_irq_edge_select = misc_control_two_q[TOP_EDGE_BIT];
    assign top_irq_enable = misc_control_two_q[TOP_EN_BIT];
    assign slave_select_source = misc_control_two_q[SS_SRC_BIT];
    assign slave_select_internal_level = misc_control_two_q[SS_LVL_BIT];

    assign level_three = cpu_irq_level_high_bit & cpu_irq_level_low_bit;
    assign wr_one = wr && (addr == MISC_ONE_ADDR);
    assign wr_two = wr && (addr == MISC_TWO_ADDR);

    // Control register one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            misc_control_one_q <= MISC_RESET;
        end
        else if (wr_one)
        begin
            misc_control_one_q[CLKOUT_BIT] <= wdata[CLKOUT_BIT];
            misc_control_one_q[SLOW_DIV_LSB +: 2] <= wdata[SLOW_DIV_LSB +: 2];
            misc_control_one_q[SLOW_MODE_BIT] <= wdata[SLOW_MODE_BIT];
            if (level_three)
            begin
                // Sensitivity fields locked below level three
                misc_control_one_q[PB_SENSE_LSB +: 2] <=
                    wdata[PB_SENSE_LSB +: 2];
                misc_control_one_q[PAF_SENSE_LSB +: 2] <=
                    wdata[PAF_SENSE_LSB +: 2];
            end
        end
    end

    // Control register two
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            misc_control_two_q <= MISC_RESET;
        end
        else if (wr_two)
        begin
            misc_control_two_q[PA_INV_BIT] <= wdata[PA_INV_BIT];
            misc_control_two_q[PB_INV_BIT] <= wdata[PB_INV_BIT];
            misc_control_two_q[TONE_LSB +: 2] <= wdata[TONE_LSB +: 2];
            misc_control_two_q[TOP_EN_BIT] <= wdata[TOP_EN_BIT];
            misc_control_two_q[SS_SRC_BIT] <= wdata[SS_SRC_BIT];
            misc_control_two_q[SS_LVL_BIT] <= wdata[SS_LVL_BIT];
            if (!top_irq_enable)
            begin
                // Edge select frozen while detection is on
                misc_control_two_q[TOP_EDGE_BIT] <=
                    wdata[TOP_EDGE_BIT];
            end
        end
    end

    // Interrupt groups: port A, port F, port B low, port B high
    mcr_sense #(.W(4)) u_porta
    (
        .clk(clk),
        .rst(rst),
        .pins(porta_irq_pins),
        .sense_sel(porta_portf_irq_sense_sel),
        .invert(porta_irq_polarity_invert),
        .req(grp_req[ST_PA])
    );

    mcr_sense #(.W(3)) u_portf
    (
        .clk(clk),
        .rst(rst),
        .pins(portf_irq_pins),
        .sense_sel(porta_portf_irq_sense_sel),
        .invert(1'b0),
        .req(grp_req[ST_PF])
    );

    mcr_sense #(.W(4)) u_portb_low
    (
        .clk(clk),
        .rst(rst),
        .pins(portb_irq_pins[3:0]),
        .sense_sel(portb_irq_sense_sel),
        .invert(portb_irq_polarity_invert),
        .req(grp_req[ST_PB_LOW])
    );

    mcr_sense #(.W(4)) u_portb_high
    (
        .clk(clk),
        .rst(rst),
        .pins(portb_irq_pins[7:4]),
        .sense_sel(portb_irq_sense_sel),
        .invert(1'b0),
        .req(grp_req[ST_PB_HIGH])
    );

    // Top-level pin synchroniser and edge history
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            top_meta_q <= 1'b1;
            top_sync_q <= 1'b1;
            top_prev_q <= 1'b1;
        end
        else
        begin
            top_meta_q <= top_irq_pin;
            top_sync_q <= top_meta_q;
            top_prev_q <= top_sync_q;
        end
    end

    // Enable is not qualified by pin state, so a clear may slip one edge
    assign top_edge = top_irq_enable &&
        (top_irq_edge_select ? (~top_prev_q & top_sync_q)
                             : (top_prev_q & ~top_sync_q));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_irq_req_q <= 4'h0;
            top_level_interrupt_q <= 1'b0;
        end
        else
        begin
            ext_irq_req_q <= grp_req;
            top_level_interrupt_q <= top_edge;
        end
    end

    // Sticky status, write one to clear; a new event wins
    assign irq_events = {top_edge, grp_req};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat_q <= '0;
        end
        else if (wr && (addr == IRQ_STAT_ADDR))
        begin
            irq_stat_q <= (irq_stat_q & ~wdata[IRQ_W-1:0]) | irq_events;
        end
        else
        begin
            irq_stat_q <= irq_stat_q | irq_events;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_q <= '0;
        end
        else if (wr && (addr == IRQ_MASK_ADDR))
        begin
            irq_mask_q <= wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data, one cycle after the strobe only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
        end
        else if (rd)
        begin
            case (addr)
                MISC_ONE_ADDR: rdata_q <= misc_control_one_q;
                MISC_TWO_ADDR: rdata_q <= misc_control_two_q;
                IRQ_STAT_ADDR: rdata_q <= {3'h0, irq_stat_q};
                IRQ_MASK_ADDR: rdata_q <= {3'h0, irq_mask_q};
                default: rdata_q <= 8'h00;
            endcase
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    // CPU clock ratio
    always_comb
    begin
        if (!slow_mode_select)
        begin
            div_ratio = NORMAL_RATIO;
        end
        else
        begin
            case (slow_clock_divider_sel)
                SLOW_DIV4: div_ratio = RATIO_DIV4;
                SLOW_DIV8: div_ratio = RATIO_DIV8;
                SLOW_DIV16: div_ratio = RATIO_DIV16;
                SLOW_DIV32: div_ratio = RATIO_DIV32;
                default: div_ratio = RATIO_DIV4;
            endcase
        end
    end

    // One enable pulse per ratio oscillator cycles
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_q <= 6'h00;
            cpu_clk_en_q <= 1'b0;
        end
        else if (div_cnt_q >= div_ratio - 6'h01)
        begin
            div_cnt_q <= 6'h00;
            cpu_clk_en_q <= 1'b1;
        end
        else
        begin
            div_cnt_q <= div_cnt_q + 6'h01;
            cpu_clk_en_q <= 1'b0;
        end
    end

    // Clock-out: toggles each cycle, parked low in active halt
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clock_out_pin_q <= 1'b0;
            clock_out_sel_q <= 1'b0;
        end
        else
        begin
            clock_out_sel_q <= clock_out_enable;
            if (clock_out_enable && !active_halt)
            begin
                clock_out_pin_q <= ~clock_out_pin_q;
            end
            else
            begin
                clock_out_pin_q <= 1'b0;
            end
        end
    end

    // Tone half period in oscillator cycles
    always_comb
    begin
        case (tone_select)
            TONE_HIGH: tone_half = 16'(TONE_HALF);
            TONE_MID: tone_half = 16'(TONE_HALF * 2);
            TONE_LOW: tone_half = 16'(TONE_HALF * 4);
            default: tone_half = 16'h0001;
        endcase
    end

    // Square tone, unaffected by active halt
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tone_cnt_q <= 16'h0000;
            tone_pin_q <= 1'b0;
            tone_sel_q <= 1'b0;
        end
        else
        begin
            tone_sel_q <= (tone_select != TONE_OFF);
            if (tone_select == TONE_OFF)
            begin
                tone_cnt_q <= 16'h0000;
                tone_pin_q <= 1'b0;
            end
            else if (tone_cnt_q >= tone_half - 16'h0001)
            begin
                tone_cnt_q <= 16'h0000;
                tone_pin_q <= ~tone_pin_q;
            end
            else
            begin
                tone_cnt_q <= tone_cnt_q + 16'h0001;
            end
        end
    end

    // Slave-select pin synchroniser and source mux
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ss_meta_q <= 1'b1;
            ss_sync_q <= 1'b1;
            spi_ss_level_n_q <= 1'b1;
            slave_select_pin_free_q <= 1'b0;
        end
        else
        begin
            ss_meta_q <= slave_select_pin_n;
            ss_sync_q <= ss_meta_q;
            slave_select_pin_free_q <= slave_select_source;
            spi_ss_level_n_q <= slave_select_source
                ? slave_select_internal_level : ss_sync_q;
        end
    end

    assign rdata = rdata_q;
    assign ext_irq_req = ext_irq_req_q;
    assign top_level_interrupt = top_level_interrupt_q;
    assign irq = irq_q;
    assign cpu_clk_en = cpu_clk_en_q;
    assign clock_out_pin = clock_out_pin_q;
    assign clock_out_sel = clock_out_sel_q;
    assign tone_pin = tone_pin_q;
    assign tone_sel = tone_sel_q;
    assign spi_ss_level_n = spi_ss_level_n_q;
    assign slave_select_pin_free = slave_select_pin_free_q;
endmodule

// ---- tb/mcr_top_asserts.sv ----
// Port checker for the control register block
`timescale 1ns/1ps
module mcr_top_asserts
    import mcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    // CPU state
    input wire logic cpu_irq_level_high_bit,
    input wire logic cpu_irq_level_low_bit,
    input wire logic active_halt,
    // Watched outputs
    input wire logic top_level_interrupt,
    input wire logic cpu_clk_en,
    input wire logic clock_out_pin,
    input wire logic clock_out_sel,
    input wire logic tone_pin,
    input wire logic tone_sel,
    input wire logic spi_ss_level_n,
    input wire logic slave_select_pin_free
);
    logic [7:0] one_q, two_q;
    logic [6:0] quiet_q;
    logic [5:0] gap_q, ratio;
    logic lvl3, wr_one;
    assign lvl3 = cpu_irq_level_high_bit & cpu_irq_level_low_bit;
    assign wr_one = wr && addr == MISC_ONE_ADDR;
    assign ratio = one_q[0] ? 6'h04 << {one_q[1], one_q[2]} : 6'h02;
    // Register copies with the write guards applied
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            one_q <= 8'h00;
            two_q <= 8'h00;
        end
        else if (wr_one)
            one_q <= lvl3 ? wdata : {one_q[7:6], wdata[5], one_q[4:3],
                wdata[2:0]};
        else if (wr && addr == MISC_TWO_ADDR)
            two_q <= {wdata[7:4], two_q[2] ? two_q[3] : wdata[3],
                wdata[2:0]};
    end
    // Cycles since the last divider write and the last enable pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            quiet_q <= 7'h00;
            gap_q <= 6'h00;
        end
        else
        begin
            quiet_q <= wr_one ? 7'h00 : quiet_q + {6'h00, quiet_q != 7'h7f};
            gap_q <= cpu_clk_en ? 6'h00 : gap_q + 6'h01;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    reg_one_read_a: assert property (
        rd && addr == MISC_ONE_ADDR |=> rdata == $past(one_q))
        else $error("register one read back wrong");
    reg_two_read_a: assert property (
        rd && addr == MISC_TWO_ADDR |=> rdata == $past(two_q))
        else $error("register two read back wrong");
    clkout_halt_a: assert property (active_halt |=> !clock_out_pin)
        else $error("clock out active in halt");
    clkout_toggle_a: assert property (
        (clock_out_sel && !active_halt) [*3]
        |-> clock_out_pin != $past(clock_out_pin))
        else $error("clock out not toggling");
    cpu_div_a: assert property (
        cpu_clk_en && quiet_q > 7'h40 |-> gap_q == ratio - 6'h01)
        else $error("cpu clock enable spacing wrong");
    tone_off_a: assert property (
        !tone_sel && !$past(tone_sel) |-> !tone_pin)
        else $error("tone pin active while off");
    top_off_a: assert property (
        (!two_q[2]) [*4] |-> !top_level_interrupt)
        else $error("top interrupt while disabled");
    ss_internal_a: assert property (
        slave_select_pin_free && $past(slave_select_pin_free)
        |-> spi_ss_level_n == $past(two_q[0]))
        else $error("internal slave select level wrong");
endmodule

bind mcr_top mcr_top_asserts i_chk (.*);

// ---- tb/mcr_pins.sv ----
// Far-side model: CPU level, halt state and external pins
`timescale 1ns/1ps
module mcr_pins
(
    // Clock
    input wire logic clk,
    // CPU state
    output logic cpu_irq_level_high_bit,
    output logic cpu_irq_level_low_bit,
    output logic active_halt,
    // Pins, pulled up while idle
    output logic [3:0] porta_irq_pins,
    output logic [7:0] portb_irq_pins,
    output logic [2:0] portf_irq_pins,
    output logic top_irq_pin,
    output logic slave_select_pin_n
);
    initial
    begin
        cpu_irq_level_high_bit = 1'b0;
        cpu_irq_level_low_bit = 1'b0;
        active_halt = 1'b0;
        {porta_irq_pins, portb_irq_pins, portf_irq_pins} = 15'h7fff;
        top_irq_pin = 1'b1;
        slave_select_pin_n = 1'b1;
    end
    // Sensitivity changes only after level three is raised
    task automatic set_cpu(input logic three, input logic halt);
        @(posedge clk);
        cpu_irq_level_high_bit <= three;
        cpu_irq_level_low_bit <= three;
        active_halt <= halt;
    endtask
    task automatic drive(input logic [16:0] v);
        @(posedge clk);
        {porta_irq_pins, portb_irq_pins, portf_irq_pins} <= v[16:2];
        top_irq_pin <= v[1];
        slave_select_pin_n <= v[0];
    endtask
endmodule

// ---- tb/mcr_top_bench.sv ----
// Self-checking bench for the control register block
`timescale 1ns/1ps
module mcr_top_bench
    import mcr_pkg::*;
();
    logic clk = 1'b0;
    logic rst, wr, rd, irq, cpu_clk_en, active_halt;
    logic cpu_irq_level_high_bit, cpu_irq_level_low_bit;
    logic top_irq_pin, top_level_interrupt, slave_select_pin_n;
    logic clock_out_pin, clock_out_sel, tone_pin, tone_sel;
    logic spi_ss_level_n, slave_select_pin_free;
    logic [7:0] addr, wdata, rdata, portb_irq_pins;
    logic [3:0] porta_irq_pins, ext_irq_req;
    logic [2:0] portf_irq_pins;
    int miscompares = 0;
    int compares = 0;
    int cp, ct, ce, tp;
    logic [3:0] m [4];
    logic [2:0] cpc [5] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h7};

    always #10 clk = ~clk;

    mcr_top #(.TONE_HALF(4)) i_dut (.*);
    mcr_pins i_pins (.*);

    task automatic check(input string n, input logic [7:0] s,
        input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a,
        input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(n, rdata, e);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    // Bits: fall, rise, low level, high level
    function automatic logic [3:0] sens(input logic [1:0] c, input logic i);
        case (c)
            2'h0: sens = i ? 4'h5 : 4'ha;
            2'h1: sens = i ? 4'h8 : 4'h4;
            2'h2: sens = i ? 4'h4 : 4'h8;
            default: sens = 4'hc;
        endcase
    endfunction
    task automatic count_edges(input int n);
        logic pc;
        logic pt;
        cp = 0;
        ct = 0;
        ce = 0;
        tp = 0;
        @(negedge clk);
        pc = clock_out_pin;
        pt = tone_pin;
        repeat (n)
        begin
            @(negedge clk);
            cp += int'(clock_out_pin !== pc);
            ct += int'(tone_pin !== pt);
            ce += int'(cpu_clk_en === 1'b1);
            tp += int'(top_level_interrupt === 1'b1);
            pc = clock_out_pin;
            pt = tone_pin;
        end
    endtask
    // Odd steps clear the status, even steps move the pins
    task automatic step(input logic [16:0] v, input int k);
        logic [4:0] e;
        logic [3:0] q;
        if (k % 2 == 1)
            wr_reg(IRQ_STAT_ADDR, 8'h1f);
        else
            i_pins.drive(v);
        repeat (6) @(posedge clk);
        @(negedge clk);
        for (int g = 0; g < 4; g++)
        begin
            case (k)
                0: e[g] = m[g][3] | m[g][0];
                1: e[g] = m[g][1];
                2: e[g] = m[g][2] | m[g][1];
                default: e[g] = m[g][0];
            endcase
            q[g] = k < 2 ? m[g][1] : m[g][0];
        end
        e[4] = 1'b0;
        check("ext_irq_req", 8'(ext_irq_req), 8'(q));
        rd_chk("status", IRQ_STAT_ADDR, 8'(e));
        check("irq", 8'(irq), 8'(e[0]));
    endtask
    task automatic top_step(input logic t, input int n);
        i_pins.drive({15'h7fff, t, 1'b1});
        count_edges(8);
        check("top pulses", 8'(tp), 8'(n));
    endtask
    task automatic ss_chk(input logic [7:0] e);
        repeat (5) @(posedge clk);
        @(negedge clk);
        check("slave select", {6'h00, slave_select_pin_free,
            spi_ss_level_n}, e);
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        do_reset();
        @(negedge clk);
        check("outputs", {clock_out_pin, clock_out_sel, tone_pin, tone_sel,
            irq, slave_select_pin_free, spi_ss_level_n, 1'b0}, 8'h02);
        rd_chk("one", MISC_ONE_ADDR, 8'h00);
        rd_chk("two", MISC_TWO_ADDR, 8'h00);
        rd_chk("status", IRQ_STAT_ADDR, 8'h00);
        wr_reg(8'h30, 8'hff);
        rd_chk("unmapped", 8'h30, 8'h00);
        wr_reg(IRQ_MASK_ADDR, 8'hff);
        rd_chk("mask", IRQ_MASK_ADDR, 8'h1f);
        wr_reg(IRQ_MASK_ADDR, 8'h01);
        wr_reg(MISC_ONE_ADDR, 8'hff);
        rd_chk("one guarded", MISC_ONE_ADDR, 8'h27);
        i_pins.set_cpu(1'b1, 1'b0);
        wr_reg(MISC_ONE_ADDR, 8'hff);
        rd_chk("one at level3", MISC_ONE_ADDR, 8'hff);
        $display("test registers done");
        for (int c = 0; c < 4; c++)
            for (int v = 0; v < 2; v++)
            begin
                wr_reg(MISC_ONE_ADDR, {c[1:0], 1'b0, c[1:0], 3'h0});
                wr_reg(MISC_TWO_ADDR, {v[0], ~v[0], 6'h00});
                for (int g = 0; g < 4; g++)
                    m[g] = sens(c[1:0], g == 0 ? v[0] : g == 2 && !v[0]);
                repeat (4) @(posedge clk);
                wr_reg(IRQ_STAT_ADDR, 8'h1f);
                step(17'h00003, 0);
                step(17'h00003, 1);
                step(17'h1ffff, 2);
                step(17'h1ffff, 3);
            end
        $display("test sensitivity done");
        wr_reg(MISC_TWO_ADDR, 8'h0c);
        top_step(1'b0, 0);
        top_step(1'b1, 1);
        wr_reg(MISC_TWO_ADDR, 8'h04);
        rd_chk("edge held", MISC_TWO_ADDR, 8'h0c);
        wr_reg(MISC_TWO_ADDR, 8'h00);
        top_step(1'b0, 0);
        top_step(1'b1, 0);
        rd_chk("edge kept", MISC_TWO_ADDR, 8'h08);
        wr_reg(MISC_TWO_ADDR, 8'h00);
        wr_reg(MISC_TWO_ADDR, 8'h04);
        top_step(1'b0, 1);
        top_step(1'b1, 0);
        wr_reg(MISC_TWO_ADDR, 8'h00);
        $display("test top interrupt done");
        for (int i = 0; i < 5; i++)
        begin
            i_pins.set_cpu(1'b1, i[0]);
            wr_reg(MISC_ONE_ADDR, {2'h0, 1'b1, 2'h0, cpc[i]});
            wr_reg(MISC_TWO_ADDR, {2'h0, i[1:0], 4'h0});
            repeat (40) @(posedge clk);
            count_edges(64);
            check("clock out", 8'(cp),
                i[0] ? 8'h00 : 8'h40);
            check("cpu clock", 8'(ce), 8'(64 >> (i + 1)));
            check("tone", 8'(ct),
                i[1:0] == 0 ? 8'h00 : 8'(32 >> i[1:0]));
            check("selects", 8'({clock_out_sel, tone_sel}),
                8'({1'b1, i[1:0] != 2'h0}));
        end
        i_pins.set_cpu(1'b1, 1'b0);
        wr_reg(MISC_ONE_ADDR, 8'h00);
        $display("test clocks done");
        i_pins.drive(17'h1fffe);
        ss_chk(8'h00);
        wr_reg(MISC_TWO_ADDR, 8'h03);
        ss_chk(8'h03);
        i_pins.drive(17'h1ffff);
        wr_reg(MISC_TWO_ADDR, 8'h02);
        ss_chk(8'h02);
        $display("test slave select done");
        wr_reg(MISC_ONE_ADDR, 8'h21);
        do_reset();
        rd_chk("one", MISC_ONE_ADDR, 8'h00);
        rd_chk("two", MISC_TWO_ADDR, 8'h00);
        $display("test second reset done");
        complete_run();
    end
endmodule
